// ---- verification/abz_link_properties.sv ----
`timescale 1ns/100ps
module abz_link_props
  import abz_cfg_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Level wires
  input wire logic [3:0] factor_select_input,
  input wire logic [3:0] adapt_group_select_input,
  input wire logic [3:0] filter_hyst_select_input,
  input wire logic [3:0] rate_limit_select_input,
  // Output wires
  input wire logic a_out,
  input wire logic b_out,
  input wire logic index_out,
  input wire logic fault_n,
  // Index gating mode
  input wire logic frac_factor
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_edge;
    $changed({a_out, b_out});
  endsequence
  sequence s_fault_held;
    !fault_n [*3];
  endsequence

  property p_levels_legal;
    factor_select_input <= LVL_MAX && adapt_group_select_input <= LVL_MAX &&
      filter_hyst_select_input <= LVL_MAX && rate_limit_select_input <= LVL_MAX;
  endproperty
  a_levels_legal: assert property (p_levels_legal)
    else $error("level above eleven");

  // Decade group carries no demand, so only groups 0 and 2 are checked
  property p_top_factor;
    factor_select_input == FACTOR_TOP && (adapt_group_select_input % 3) != 1
      |-> filter_hyst_select_input >= FILT_HEAVY_MIN &&
          rate_limit_select_input >= LAG_MIN;
  endproperty
  a_top_factor: assert property (p_top_factor)
    else $error("top factor without heavy filter and recovery");

  property p_second_factor;
    factor_select_input == FACTOR_SECOND &&
      (adapt_group_select_input % 3) != 1
      |-> filter_hyst_select_input >= FILT_NORM_MIN &&
          rate_limit_select_input >= LAG_MIN;
  endproperty
  a_second_factor: assert property (p_second_factor)
    else $error("second factor without filter and recovery");

  property p_gray_step;
    !($changed(a_out) && $changed(b_out));
  endproperty
  a_gray_step: assert property (p_gray_step)
    else $error("both quadrature lines moved together");

  property p_edge_gap;
    s_edge |=> $stable({a_out, b_out});
  endproperty
  a_edge_gap: assert property (p_edge_gap)
    else $error("edges closer than two cycles");

  property p_fault_latch;
    !fault_n |=> !fault_n;
  endproperty
  a_fault_latch: assert property (p_fault_latch)
    else $error("fault released without reset");

  property p_frozen_on_fault;
    s_fault_held |-> $stable({a_out, b_out});
  endproperty
  a_frozen_on_fault: assert property (p_frozen_on_fault)
    else $error("stepping while faulted");

  property p_reset_defaults;
    $rose(rst_n) |-> fault_n && rate_limit_select_input == DEF_RATE &&
      adapt_group_select_input == DEF_ADAPT &&
      filter_hyst_select_input == DEF_FILTER;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults)
    else $error("wrong state after reset");

  property p_index_sync;
    index_out && !frac_factor |-> a_out && b_out;
  endproperty
  a_index_sync: assert property (p_index_sync)
    else $error("index not aligned with quadrature");
endmodule

// ---- verification/abz_pin_config_decode_tb_top.sv ----
`timescale 1ns/100ps
module abz_pin_config_decode_tb_top
  import abz_cfg_pkg::*;
;
  logic clk, rst_n, read, write, waitrequest, params_ready, index_in;
  logic frac_factor, running, lag_recovery;
  logic [3:0] address, hyst_edges;
  logic [31:0] writedata, readdata, sensor_pos, edges_per_cycle;
  logic [4:0] adjust_en;
  logic [2:0] rate_code;
  adapt_t adapt_mode;
  group_t factor_group;
  filt_t filter_mode;
  int mismatches = 0;
  int samples_checked = 0;

  abz_link_if link();
  abz_cfg_host abz_cfg_host_i (.clk(clk), .rst_n(rst_n), .link(link),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest));
  abz_pin_config_decode #(.SETTLE(4)) abz_pin_config_decode_i (.clk(clk),
    .rst_n(rst_n), .link(link), .params_ready(params_ready),
    .sensor_pos(sensor_pos), .edges_per_cycle(edges_per_cycle),
    .index_in(index_in), .frac_factor(frac_factor), .running(running),
    .adapt_mode(adapt_mode), .factor_group(factor_group),
    .adjust_en(adjust_en), .filter_mode(filter_mode),
    .hyst_edges(hyst_edges), .lag_recovery(lag_recovery),
    .rate_code(rate_code));
  abz_link_props abz_link_props_i (.clk(clk), .rst_n(rst_n),
    .factor_select_input(link.factor_select_input),
    .adapt_group_select_input(link.adapt_group_select_input),
    .filter_hyst_select_input(link.filter_hyst_select_input),
    .rate_limit_select_input(link.rate_limit_select_input),
    .a_out(link.a_out), .b_out(link.b_out), .index_out(link.index_out),
    .fault_n(link.fault_n), .frac_factor(frac_factor));

  task tally_and_finish();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Request held until waitrequest is sampled low, then one idle edge
  task bus_cycle(input logic [3:0] a, input logic wr, input logic [31:0] wd,
                 output logic [31:0] rd);
    int n;
    address <= a;
    writedata <= wd;
    read <= !wr;
    write <= wr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (waitrequest !== 1'b0)
      mismatches++;
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask

  task do_reset();
    rst_n <= 1'b0;
    params_ready <= 1'b0;
    sensor_pos <= 32'h0000_0000;
    index_in <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask

  task start_up(input logic [31:0] cfg);
    logic [31:0] d;
    int n;
    bus_cycle(CFG_ADDR, 1'b1, cfg, d);
    params_ready <= 1'b1;
    n = 0;
    while (running !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    if (running !== 1'b1)
      mismatches++;
  endtask

  task decode_sweep();
    logic [3:0] lv;
    logic [31:0] d;
    logic [4:0] ae [4] = '{5'h00, 5'h06, 5'h07, 5'h1f};
    for (int i = 0; i < 12; i++) begin
      lv = i[3:0];
      do_reset();
      start_up({16'h0000, lv, lv, lv, 4'h0});
      chk(adapt_mode, i / 3);
      chk(factor_group, i % 3);
      chk(adjust_en, ae[i / 3]);
      chk(filter_mode, i / 4);
      chk(hyst_edges, 8 >> (i % 4));
      chk(lag_recovery, i >= 6);
      chk(rate_code, 5 - (i % 6));
    end
    bus_cycle(CFG_ADDR, 1'b1, 32'h0000_0000, d);
    chk(adapt_mode, 3);
  endtask

  task demand_table();
    logic [31:0] w [4] = '{32'h0000_680b, 32'h0000_642a, 32'h0000_670b,
                           32'h0000_540a};
    logic ok [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    logic [31:0] d, kept;
    do_reset();
    for (int i = 0; i < 4; i++) begin
      bus_cycle(CFG_ADDR, 1'b1, w[i], d);
      if (ok[i])
        kept = w[i];
      bus_cycle(CFG_ADDR, 1'b0, 32'h0000_0000, d);
      chk(d[15:0], kept[15:0]);
      bus_cycle(STAT_ADDR, 1'b0, 32'h0000_0000, d);
      chk(d[1], i >= 2);
    end
    bus_cycle(4'hc, 1'b0, 32'h0000_0000, d);
    chk(d, 32'h0000_0000);
  endtask

  task run_motion();
    logic [31:0] d;
    do_reset();
    start_up(32'h0000_b360);
    sensor_pos <= 32'h0000_0002;
    index_in <= 1'b1;
    repeat (60) @(posedge clk);
    chk({link.b_out, link.a_out}, 2'b11);
    chk(link.index_out, 1'b1);
    bus_cycle(POS_ADDR, 1'b0, 32'h0000_0000, d);
    chk(d, 32'h0000_0002);
    sensor_pos <= 32'h0000_0009;
    repeat (60) @(posedge clk);
    bus_cycle(POS_ADDR, 1'b0, 32'h0000_0000, d);
    chk(d, 32'h0000_0009);
    chk(link.fault_n, 1'b1);
    sensor_pos <= 32'h0000_0011;
    repeat (60) @(posedge clk);
    chk(link.fault_n, 1'b0);
    bus_cycle(POS_ADDR, 1'b0, 32'h0000_0000, d);
    chk(d, 32'h0000_0009);
    bus_cycle(STAT_ADDR, 1'b0, 32'h0000_0000, d);
    chk(d[0], 1'b1);
    chk(d[2], 1'b1);
    // Frozen at an AB state off the index gate, so the clear sticks
    bus_cycle(STAT_ADDR, 1'b1, 32'h0000_0004, d);
    bus_cycle(STAT_ADDR, 1'b0, 32'h0000_0000, d);
    chk(d[2], 1'b0);
    frac_factor <= 1'b1;
    repeat (2) @(posedge clk);
    chk(link.index_out, 1'b1);
    frac_factor <= 1'b0;
    do_reset();
    chk(link.fault_n, 1'b1);
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end

  initial begin
    rst_n = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 4'h0;
    writedata = 32'h0000_0000;
    params_ready = 1'b0;
    sensor_pos = 32'h0000_0000;
    edges_per_cycle = 32'h0000_0010;
    index_in = 1'b0;
    frac_factor = 1'b0;
    @(posedge clk);
    decode_sweep();
    demand_table();
    run_motion();
    tally_and_finish();
  end
endmodule

// ---- verilog/abz_cfg_host.sv ----
`timescale 1ns/100ps
module abz_cfg_host
  import abz_cfg_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Link to the interpolator
  abz_link_if.host link,
  // Avalon-MM slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest
);
  typedef struct packed {
    logic [3:0] c0;
    logic [3:0] c1;
    logic [3:0] c2;
    logic [3:0] c3;
    logic wait_q;
    logic [31:0] rdata;
    logic reject;
    logic index_seen;
    logic [1:0] ab_prev;
    logic [POS_W-1:0] count;
  } host_t;

  host_t h_q, h_d;

  function automatic logic [1:0] ab_pos(input logic a, input logic b);
    return {b, a ^ b};
  endfunction

  // Top two factors of the non-decade groups need extra filtering
  function automatic logic cfg_ok(input logic [31:0] w);
    logic [3:0] f;
    logic [3:0] g;
    logic [3:0] fl;
    logic [3:0] r;
    logic wide;
    f = w[3:0];
    g = w[7:4];
    fl = w[11:8];
    r = w[15:12];
    wide = (g % TRIPLE) != 4'h0001;
    cfg_ok = 1'b1;
    if (wide && f == FACTOR_TOP) begin
      cfg_ok = fl >= FILT_HEAVY_MIN && r >= LAG_MIN; // see [R10]
    end else if (wide && f == FACTOR_SECOND) begin
      cfg_ok = fl >= FILT_NORM_MIN && r >= LAG_MIN; // see [R11]
    end
    if (f > LVL_MAX || g > LVL_MAX || fl > LVL_MAX || r > LVL_MAX) begin
      cfg_ok = 1'b0;
    end
  endfunction

  always_comb begin
    logic [1:0] cur;
    logic [1:0] step;
    cur = ab_pos(link.a_out, link.b_out);
    step = cur - h_q.ab_prev;
    h_d = h_q;
    h_d.ab_prev = cur;
    // Skipped states cannot be resolved, so they are not counted
    if (step == 2'b01) begin
      h_d.count = h_q.count + 32'h0000_0001;
    end else if (step == 2'b11) begin
      h_d.count = h_q.count - 32'h0000_0001;
    end
    h_d.wait_q = 1'b1;
    if ((read || write) && h_q.wait_q) begin
      h_d.wait_q = 1'b0;
      unique case (address)
        CFG_ADDR: h_d.rdata = {16'h0000, h_q.c3, h_q.c2, h_q.c1, h_q.c0};
        STAT_ADDR: h_d.rdata = {29'h0000_0000, h_q.index_seen, h_q.reject,
                                ~link.fault_n};
        POS_ADDR: h_d.rdata = h_q.count;
        default: h_d.rdata = 32'h0000_0000;
      endcase
    end
    if (write && !h_q.wait_q) begin
      if (address == CFG_ADDR) begin
        if (cfg_ok(writedata)) begin
          h_d.c0 = writedata[3:0];
          h_d.c1 = writedata[7:4];
          h_d.c2 = writedata[11:8];
          h_d.c3 = writedata[15:12];
          h_d.reject = 1'b0;
        end else begin
          h_d.reject = 1'b1;
        end
      end else if (address == STAT_ADDR && writedata[STAT_INDEX]) begin
        h_d.index_seen = 1'b0;
      end
    end
    // Set wins over the software clear
    if (link.index_out) begin
      h_d.index_seen = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      h_q <= '0;
      h_q.c0 <= DEF_FACTOR;
      h_q.c1 <= DEF_ADAPT; // see [R18]
      h_q.c2 <= DEF_FILTER; // see [R19]
      h_q.c3 <= DEF_RATE; // see [R17]
      h_q.wait_q <= 1'b1;
    end else begin
      h_q <= h_d;
    end
  end

  assign link.factor_select_input = h_q.c0;
  assign link.adapt_group_select_input = h_q.c1;
  assign link.filter_hyst_select_input = h_q.c2;
  assign link.rate_limit_select_input = h_q.c3;
  assign readdata = h_q.rdata;
  assign waitrequest = h_q.wait_q;
endmodule

// ---- verilog/abz_cfg_pkg.sv ----
package abz_cfg_pkg;
  localparam int LVL_W = 4;
  localparam int POS_W = 32;
  localparam logic [3:0] LVL_MAX = 4'h000b;
  // Adaption and group decode of the second input
  localparam logic [3:0] ADAPT_A3_MIN = 4'h0009;
  localparam logic [3:0] ADAPT_A2_MIN = 4'h0006;
  localparam logic [3:0] ADAPT_A1_MIN = 4'h0003;
  localparam logic [3:0] TRIPLE = 4'h0003;
  // Filter and hysteresis decode of the third input
  localparam logic [3:0] FILT_HEAVY_MIN = 4'h0008;
  localparam logic [3:0] FILT_NORM_MIN = 4'h0004;
  localparam logic [3:0] FILT_GROUP = 4'h0004;
  // Rate limit and lag recovery decode of the fourth input
  localparam logic [3:0] LAG_MIN = 4'h0006;
  localparam logic [3:0] RATE_STEPS = 4'h0006;
  localparam int RATE_DIV_MIN = 8;
  localparam int EDGES_PER_CYCLE = 4;
  localparam int EDGE_GAP_MIN = RATE_DIV_MIN / EDGES_PER_CYCLE;
  // Factor levels with filter and lag demands
  localparam logic [3:0] FACTOR_TOP = 4'h000b;
  localparam logic [3:0] FACTOR_SECOND = 4'h000a;
  // Filter shifts and standstill detection
  localparam logic [4:0] SHIFT_MINIMAL = 5'h0001;
  localparam logic [4:0] SHIFT_NORMAL = 5'h0003;
  localparam logic [4:0] SHIFT_HEAVY = 5'h0005;
  localparam logic [4:0] LAG_SHIFT_EXTRA = 5'h0002;
  localparam logic [3:0] STILL_CYCLES = 4'h000f;
  // Settle wait: 1048 ms per MHz of clock, in cycles
  localparam int SETTLE_MS_MHZ = 1048;
  localparam int SETTLE_CYCLES = SETTLE_MS_MHZ * 1000;
  // Host register map and recommended start levels
  localparam logic [3:0] CFG_ADDR = 4'h0000;
  localparam logic [3:0] STAT_ADDR = 4'h0004;
  localparam logic [3:0] POS_ADDR = 4'h0008;
  localparam logic [3:0] DEF_FACTOR = 4'h0000;
  localparam logic [3:0] DEF_ADAPT = 4'h0006;
  localparam logic [3:0] DEF_FILTER = 4'h0003;
  localparam logic [3:0] DEF_RATE = 4'h0005;
  localparam int STAT_FAULT = 0;
  localparam int STAT_REJECT = 1;
  localparam int STAT_INDEX = 2;

  typedef enum logic [1:0] {
    adapt_none = 2'b00,
    adapt_offset_gain_only = 2'b01,
    adapt_full_digital = 2'b10,
    adapt_full_analog_digital = 2'b11
  } adapt_t;

  typedef enum logic [1:0] {
    binary_factor_group = 2'b00,
    decade_factor_group = 2'b01,
    fine_decimal_factor_group = 2'b10
  } group_t;

  typedef enum logic [1:0] {
    filt_minimal = 2'b00,
    filt_normal = 2'b01,
    filt_heavy = 2'b10
  } filt_t;

  typedef enum logic [2:0] {
    ph_load = 3'b000,
    ph_clock = 3'b001,
    ph_sample = 3'b010,
    ph_settle = 3'b011,
    ph_clear = 3'b100,
    ph_run = 3'b101
  } phase_t;
endpackage

// ---- verilog/abz_link_if.sv ----
`timescale 1ns/100ps
interface abz_link_if;
  logic [3:0] factor_select_input;
  logic [3:0] adapt_group_select_input;
  logic [3:0] filter_hyst_select_input;
  logic [3:0] rate_limit_select_input;
  logic a_out;
  logic b_out;
  logic index_out;
  logic fault_n;

  modport device (
    input factor_select_input, adapt_group_select_input,
    input filter_hyst_select_input, rate_limit_select_input,
    output a_out, b_out, index_out, fault_n
  );
  modport host (
    output factor_select_input, adapt_group_select_input,
    output filter_hyst_select_input, rate_limit_select_input,
    input a_out, b_out, index_out, fault_n
  );
endinterface

// ---- verilog/abz_pin_config_decode.sv ----
// The register offsets and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/100ps
// Summary of operation
// [R1] Second input picks adaption mode and group
// [R2] Analog-plus-digital mode adjusts all five parameters
// [R3] Full digital holds analog, adjusts digital three
// [R4] Offset-gain mode also holds digital phase
// [R5] No-adaption mode keeps every calibrated value
// [R6] Third input picks heavy, normal or minimal filter
// [R7] Hysteresis 1,2,4,8 edges top to bottom
// [R8] Fourth input levels 6-11 enable lag recovery
// [R9] AB rate limit clock/8 down to clock/256
// [R10] Top factors need heavy filter and recovery
// [R11] Second factors need normal filter and recovery
// [R12] Fractional factors leave index unsynchronised
// [R13] Lagging output steps at limit rate
// [R14] Half-cycle lag latches fault until power cycle
// [R15] Lag recovery removes constant-speed filter lag
// [R16] At standstill output equals sensor position
// [R17] Recommended fourth input level is 5
// [R18] Recommended adaption is full digital
// [R19] Start with minimal filtering
// [R20] Each input resolves twelve levels 0-11
// [R21] Inputs sampled at start-up, then path enabled
// [R22] Four AB edges per AB cycle
// [R23] Levels four bits, held until reset
module abz_pin_config_decode
  import abz_cfg_pkg::*;
#(
  parameter int SETTLE = SETTLE_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Link to the counter and configuring party
  abz_link_if.device link,
  // Start-up and sensor side
  input wire logic params_ready,
  input wire logic [POS_W-1:0] sensor_pos,
  input wire logic [POS_W-1:0] edges_per_cycle,
  input wire logic index_in,
  input wire logic frac_factor,
  // Decoded settings
  output logic running,
  output adapt_t adapt_mode,
  output group_t factor_group,
  output logic [4:0] adjust_en,
  output filt_t filter_mode,
  output logic [3:0] hyst_edges,
  output logic lag_recovery,
  output logic [2:0] rate_code
);
  typedef struct packed {
    phase_t phase;
    logic [31:0] cnt;
    logic [3:0] c0;
    adapt_t adapt;
    group_t grp;
    logic [4:0] adj;
    filt_t filt;
    logic [3:0] hyst;
    logic lag_rec;
    logic [2:0] rate;
    logic [POS_W-1:0] est;
    logic [POS_W-1:0] integ;
    logic [POS_W-1:0] out_pos;
    logic [POS_W-1:0] last;
    logic [3:0] still;
    logic [7:0] gap;
    logic fwd;
    logic a;
    logic b;
    logic z;
    logic fault_n;
    logic run;
  } dev_t;

  dev_t s_q, s_d;

  // Unresolvable levels above the top are read as the top level
  function automatic logic [3:0] clamp_lvl(input logic [3:0] l);
    return (l > LVL_MAX) ? LVL_MAX : l; // see [R20] [R23]
  endfunction

  function automatic logic [3:0] in_group(input logic [3:0] l,
                                          input logic [3:0] n);
    return l % n;
  endfunction

  // Order: analog gain, analog offset, digital offset, gain, phase
  function automatic logic [4:0] adj_mask(input adapt_t m);
    unique case (m)
      adapt_full_analog_digital: adj_mask = 5'h001f; // see [R2]
      adapt_full_digital: adj_mask = 5'h0007; // see [R3]
      adapt_offset_gain_only: adj_mask = 5'h0006; // see [R4]
      adapt_none: adj_mask = 5'h0000; // see [R5]
    endcase
  endfunction

  function automatic logic [POS_W-1:0] mag(input logic [POS_W-1:0] v);
    return v[POS_W-1] ? -v : v;
  endfunction

  always_comb begin
    logic [3:0] l1;
    logic [3:0] l2;
    logic [3:0] l3;
    logic [POS_W-1:0] diff;
    logic [POS_W-1:0] tgt;
    logic [POS_W-1:0] lag;
    logic [4:0] sh;
    logic still;
    logic [7:0] gap_set;
    l1 = clamp_lvl(link.adapt_group_select_input);
    l2 = clamp_lvl(link.filter_hyst_select_input);
    l3 = clamp_lvl(link.rate_limit_select_input);
    diff = sensor_pos - s_q.est;
    tgt = s_q.est - s_q.out_pos;
    lag = sensor_pos - s_q.out_pos;
    sh = (s_q.filt == filt_heavy) ? SHIFT_HEAVY :
         (s_q.filt == filt_normal) ? SHIFT_NORMAL : SHIFT_MINIMAL;
    still = s_q.still == STILL_CYCLES;
    gap_set = 8'((EDGE_GAP_MIN << s_q.rate) - 1); // see [R22]
    s_d = s_q;
    unique case (s_q.phase)
      ph_load: begin
        if (params_ready) begin
          s_d.phase = ph_clock; // see [R21]
        end
      end
      ph_clock: s_d.phase = ph_sample;
      ph_sample: begin
        s_d.c0 = clamp_lvl(link.factor_select_input);
        s_d.adapt = (l1 >= ADAPT_A3_MIN) ? adapt_full_analog_digital :
                    (l1 >= ADAPT_A2_MIN) ? adapt_full_digital :
                    (l1 >= ADAPT_A1_MIN) ? adapt_offset_gain_only :
                    adapt_none; // see [R1]
        s_d.grp = group_t'(2'(in_group(l1, TRIPLE))); // see [R1]
        s_d.adj = adj_mask(s_d.adapt);
        s_d.filt = (l2 >= FILT_HEAVY_MIN) ? filt_heavy :
                   (l2 >= FILT_NORM_MIN) ? filt_normal :
                   filt_minimal; // see [R6]
        // Top of group is one edge, bottom eight
        s_d.hyst = 4'(4'h0008 >> in_group(l2, FILT_GROUP)); // see [R7]
        s_d.lag_rec = l3 >= LAG_MIN; // see [R8]
        s_d.rate = 3'(RATE_STEPS - 4'h0001 -
                      in_group(l3, RATE_STEPS)); // see [R9]
        s_d.cnt = '0;
        s_d.phase = ph_settle;
      end
      ph_settle: begin
        if (s_q.cnt >= 32'(SETTLE - 1)) begin
          s_d.phase = ph_clear;
        end else begin
          s_d.cnt = s_q.cnt + 32'h0000_0001;
        end
      end
      ph_clear: begin
        s_d.fault_n = 1'b1;
        s_d.est = sensor_pos;
        s_d.out_pos = sensor_pos;
        s_d.last = sensor_pos;
        s_d.integ = '0;
        s_d.gap = '0;
        s_d.run = 1'b1;
        s_d.phase = ph_run;
      end
      ph_run: begin
        s_d.last = sensor_pos;
        if (sensor_pos != s_q.last) begin
          s_d.still = '0;
        end else if (!still) begin
          s_d.still = s_q.still + 4'h0001;
        end
        if (still) begin
          s_d.est = sensor_pos; // see [R16]
          s_d.integ = '0;
        end else begin
          s_d.est = s_q.est + 32'($signed(diff) >>> sh);
          if (s_q.lag_rec) begin
            // Integral term cancels ramp lag but can overshoot
            s_d.est = s_d.est + s_q.integ; // see [R15]
            s_d.integ = s_q.integ +
                        32'($signed(diff) >>> (sh + LAG_SHIFT_EXTRA));
          end
        end
        if (mag(lag) >= (edges_per_cycle >> 1)) begin
          s_d.fault_n = 1'b0; // see [R14]
        end
        // Once faulted the AB outputs freeze until rst_n is asserted
        if (s_q.gap != '0) begin
          s_d.gap = s_q.gap - 8'h0001;
        end else if (s_q.fault_n && tgt != '0) begin
          if (!tgt[POS_W-1] && (s_q.fwd || still ||
              tgt >= 32'(s_q.hyst))) begin
            s_d.out_pos = s_q.out_pos + 32'h0000_0001; // see [R13]
            s_d.fwd = 1'b1;
            s_d.gap = gap_set; // see [R9]
          end else if (tgt[POS_W-1] && (!s_q.fwd || still ||
                       mag(tgt) >= 32'(s_q.hyst))) begin
            s_d.out_pos = s_q.out_pos - 32'h0000_0001; // see [R13]
            s_d.fwd = 1'b0;
            s_d.gap = gap_set; // see [R9]
          end
        end
      end
      default: s_d.phase = ph_load;
    endcase
    s_d.a = s_d.run & (s_d.out_pos[1] ^ s_d.out_pos[0]); // see [R22]
    s_d.b = s_d.run & s_d.out_pos[1];
    // Index only gated by AB state when the factor is whole
    s_d.z = s_d.run & index_in &
            (frac_factor | (s_d.a & s_d.b)); // see [R12]
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.phase <= ph_load;
      s_q.fault_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign link.a_out = s_q.a;
  assign link.b_out = s_q.b;
  assign link.index_out = s_q.z;
  assign link.fault_n = s_q.fault_n;
  assign running = s_q.run;
  assign adapt_mode = s_q.adapt;
  assign factor_group = s_q.grp;
  assign adjust_en = s_q.adj;
  assign filter_mode = s_q.filt;
  assign hyst_edges = s_q.hyst;
  assign lag_recovery = s_q.lag_rec;
  assign rate_code = s_q.rate;
endmodule
